// >>> logic/mfc_glue_params.svh
/*
 constants for the multifunction configuration and bus glue block.
 included by the design file only; definitions only.
*/
`ifndef MFC_GLUE_PARAMS_SVH
`define MFC_GLUE_PARAMS_SVH

// configuration register offsets
`define OFS_FUNC_EN      4'h0
`define OFS_RST_OPT      4'h1
`define OFS_BAUD_SEL     4'h2
`define OFS_CLK_BASE     4'h3
`define OFS_SER1_BASE    4'h4
`define OFS_SER2_BASE    4'h5
`define OFS_PRN_BASE     4'h6
`define OFS_JOY_BASE     4'h7
`define OFS_IRQ_ROUTE    4'h8
`define OFS_VERIFY       4'hf

// reset values
`define RST_FUNC_EN      8'h00
`define RST_RST_OPT      8'h00
`define RST_BAUD_SEL     8'h00
`define RST_CLK_BASE     8'hb0
`define RST_SER1_BASE    8'hfe
`define RST_SER2_BASE    8'hbe
`define RST_PRN_BASE     8'h9e
`define RST_JOY_BASE     8'h80
`define RST_IRQ_ROUTE    8'hec

// field positions
`define BIT_RST_OPT      7
`define BIT_EN_CLK       4
`define BIT_EN_PRN       3
`define BIT_EN_SER2      2
`define BIT_EN_SER1      1
`define BIT_EN_JOY       0
`define BIT_VALID_CFG    7
`define LSB_IRQ3         6
`define LSB_IRQ4         4
`define LSB_IRQ5         2
`define LSB_IRQ7         0

// unit select lines start at muxed line 4
`define UNIT_LINE_BASE   4

`endif

// >>> logic/mfc_glue_pkg.sv
/*
 types for the multifunction configuration and bus glue block.
 assumes the params header is on the include path.
*/
package mfc_glue_pkg;
  typedef enum logic [1:0] {
    src_none = 2'b00,
    src_clk  = 2'b01,
    src_a    = 2'b10,
    src_b    = 2'b11
  } irq_src_t;

  typedef enum logic [1:0] {
    md_idle   = 2'b00,
    md_config = 2'b01,
    md_normal = 2'b10
  } cfg_mode_t;
endpackage : mfc_glue_pkg

// >>> logic/multifunction_config_bus_glue.sv
/*
 configuration register bank, irq routing and external buffer control
 for a pc multifunction peripheral controller.
 assumes bus strobes are synchronous to core_clk (active low ior/iow),
 an upstream entry sequence raises cfg_enter, and function cores take
 the reset and enable outputs below.
 every output is registered, so pins answer one clock after the cause.
 unit select gates configuration access only; normal decode ignores it.
*/
// Notes on behaviour
// - irq7 field: 0 none, 1 clock, 2 second uart, 3 printer; resets 0.
// - one source may drive several irq lines at once.
// - reading offset f returns the configuration index in use.
// - any write to offset f ends config mode; unit runs normally.
// - bus reset only clears clock irq logic, plus uart control regs under normal option.
// - normal option clears uart control regs; restricted leaves them.
// - bus reset leaves printer config and clock untouched.
// - power-loss flag holds while supply stays on.
// - cleared flag at power-up disables operation until configured.
// - buffer enables derived from ale, aen, ior and iow.
// - external buffer enable input can also activate data enable.
// - no address match: data enable high, direction floats.
// - recognized read: data enable and direction both low.
// - recognized write except joystick: enable low, direction high.
// - joystick write: enable high, direction floats.
// - four three-state irq outputs, each carrying its routed source.
// - power-up bases: clock 2c0, uart1 com1, uart2 com2, printer lpt2.
// - select on lines 4..7 gives unit 0..3; unconnected ignores all.
// - offsets 0-2 reset 00, 3 b0, 4 fe, 5 be, 6 9e, 7 80.
// - routing resets to ec: uart2 irq3, uart1 irq4, printer irq5.
// - irq3 bits 7-6, irq4 bits 5-4: none, clock, uart1, uart2.
// - offset 1 bit 7 picks reset option: 0 normal, 1 restricted.
`timescale 1ns/10ps
`include "mfc_glue_params.svh"

module multifunction_config_bus_glue
  import mfc_glue_pkg::*;
(
  // clock and resets
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       bus_reset,
  // host bus, already buffered
  input  wire logic       ale,
  input  wire logic       aen,
  input  wire logic       ior_n,
  input  wire logic       iow_n,
  input  wire logic [9:8] addr_hi,
  input  wire logic [7:0] muxed_addr_data,
  input  wire logic       unit_select,
  input  wire logic       unit_select_conn,
  input  wire logic       ext_buf_en_n,
  // configuration entry from the sequence detector
  input  wire logic       cfg_enter,
  // interrupt sources
  input  wire logic       irq_clk_src,
  input  wire logic       irq_ser1_src,
  input  wire logic       irq_ser2_src,
  input  wire logic       irq_prn_src,
  // buffer control
  output logic            addr_buf_en_n,
  output logic            data_buf_en_n,
  output logic            data_dir_out,
  output logic            data_dir_oe_n,
  // read data toward the data buffer
  output logic [7:0]      rd_data,
  // irq pins, three-state
  output logic [3:0]      irq_out,
  output logic [3:0]      irq_oe_n,
  // state toward function cores
  output logic            ser_ctrl_reset,
  output logic            clk_irq_reset,
  output logic            normal_op,
  output logic [4:0]      func_enable,
  output logic [7:0]      reset_options,
  output logic [7:0]      baud_select
);

  ////////////////////////////////////////////////////////////////////////
  // address latch and unit decode

  logic [9:0]  addr_r;
  logic        unit_hit_r;
  logic        unit_ok_r;
  cfg_mode_t   mode_r;
  logic [3:0]  cfg_index_r;
  logic        power_ok_r;

  // address on muxed pins only while ale is high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_r <= 10'h000;
    end else if (ale) begin
      addr_r <= {addr_hi, muxed_addr_data};
    end
  end

  // select pin level at ale says whether this unit is addressed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      unit_ok_r  <= 1'b0;
      unit_hit_r <= 1'b0;
    end else if (ale) begin
      unit_ok_r  <= unit_select_conn;
      // the wired line is high only when this unit is named
      unit_hit_r <= unit_select_conn && unit_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [7:0] func_en_r;
  logic [7:0] rst_opt_r;
  logic [7:0] baud_r;
  logic [7:0] clk_base_r;
  logic [7:0] ser1_base_r;
  logic [7:0] ser2_base_r;
  logic [7:0] prn_base_r;
  logic [7:0] joy_base_r;
  logic [7:0] route_r;

  logic ior_d_r;
  logic iow_d_r;
  logic rd_pulse;
  logic wr_pulse;
  logic cfg_sel;
  logic cfg_wr;
  logic cfg_end;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ior_d_r <= 1'b1;
      iow_d_r <= 1'b1;
    end else begin
      ior_d_r <= ior_n;
      iow_d_r <= iow_n;
    end
  end

  // edge detect: a long strobe acts once, not on every clock
  assign rd_pulse = ior_d_r && !ior_n && !aen;
  assign wr_pulse = iow_d_r && !iow_n && !aen;
  // config window: address low nibble holds the index; dead without select
  assign cfg_sel  = (mode_r == md_config) && unit_hit_r;
  // one decoded write so bank, flag and mode agree on every write
  assign cfg_wr   = wr_pulse && cfg_sel && !ale;
  assign cfg_end  = cfg_wr && cfg_index_r == `OFS_VERIFY;

  // index latched from address low nibble during config
  // normal traffic never moves the index
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_index_r <= 4'h0;
    end else if (ale && mode_r == md_config) begin
      cfg_index_r <= muxed_addr_data[3:0];
    end
  end

  // bank lives on rst only; bus reset leaves it alone
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      func_en_r   <= `RST_FUNC_EN;
      rst_opt_r   <= `RST_RST_OPT;
      baud_r      <= `RST_BAUD_SEL;
      clk_base_r  <= `RST_CLK_BASE;
      ser1_base_r <= `RST_SER1_BASE;
      ser2_base_r <= `RST_SER2_BASE;
      prn_base_r  <= `RST_PRN_BASE;
      joy_base_r  <= `RST_JOY_BASE;
      route_r     <= `RST_IRQ_ROUTE;
    end else if (cfg_wr) begin
      // unknown offsets drop; offset f has no storage
      unique case (cfg_index_r)
        `OFS_FUNC_EN:   func_en_r   <= muxed_addr_data;
        `OFS_RST_OPT:   rst_opt_r   <= muxed_addr_data;
        `OFS_BAUD_SEL:  baud_r      <= muxed_addr_data;
        `OFS_CLK_BASE:  clk_base_r  <= muxed_addr_data;
        `OFS_SER1_BASE: ser1_base_r <= muxed_addr_data;
        `OFS_SER2_BASE: ser2_base_r <= muxed_addr_data;
        `OFS_PRN_BASE:  prn_base_r  <= muxed_addr_data;
        `OFS_JOY_BASE:  joy_base_r  <= muxed_addr_data;
        `OFS_IRQ_ROUTE: route_r     <= muxed_addr_data;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode and power-loss flag

  // flag only drops with supply, i.e. rst; held otherwise
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power_ok_r <= 1'b0;
    end else if (cfg_end) begin
      // write to f both ends config and marks the setup valid
      power_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r <= md_idle;
    end else begin
      unique case (mode_r)
        md_idle:   if (cfg_enter) mode_r <= md_config;
        md_config: if (cfg_end) begin
          mode_r <= md_normal;
        end
        // re-entry from normal keeps the bank contents
        md_normal: if (cfg_enter) mode_r <= md_config;
        default:   mode_r <= md_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // function address match

  logic hit_clk;
  logic hit_ser1;
  logic hit_ser2;
  logic hit_prn;
  logic hit_joy;
  logic run;
  logic any_hit;
  logic acc_hit;

  // no decode until configured and unit connected
  assign run      = (mode_r == md_normal) && power_ok_r && unit_ok_r;
  assign hit_clk  = func_en_r[`BIT_EN_CLK] && addr_r[1] == 1'b0 &&
                    addr_r[9:2] == clk_base_r;
  assign hit_ser1 = func_en_r[`BIT_EN_SER1] &&
                    addr_r[9:3] == ser1_base_r[7:1];
  assign hit_ser2 = func_en_r[`BIT_EN_SER2] &&
                    addr_r[9:3] == ser2_base_r[7:1];
  assign hit_prn  = func_en_r[`BIT_EN_PRN] && addr_r[9:2] == prn_base_r;
  assign hit_joy  = func_en_r[`BIT_EN_JOY] && addr_r[1:0] == 2'b01 &&
                    addr_r[9:2] == joy_base_r;
  // decode uses the latched address; aen is checked live
  assign any_hit  = run && !aen &&
                    (hit_clk | hit_ser1 | hit_ser2 | hit_prn | hit_joy);
  // config registers count as a recognized function as well
  assign acc_hit  = any_hit || (cfg_sel && !aen);

  ////////////////////////////////////////////////////////////////////////
  // buffer enables and direction

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_buf_en_n <= 1'b1;
      data_buf_en_n <= 1'b1;
      data_dir_out  <= 1'b0;
      data_dir_oe_n <= 1'b1;
    end else begin
      addr_buf_en_n <= !(ale && !aen);
      data_buf_en_n <= 1'b1;
      data_dir_out  <= 1'b0;
      data_dir_oe_n <= 1'b1;
      // strobes are taken raw, so enables trail them by one clock
      if (acc_hit && !ior_n) begin
        data_buf_en_n <= 1'b0;
        data_dir_out  <= 1'b0;
        data_dir_oe_n <= 1'b0;
      end else if (acc_hit && !iow_n && !(any_hit && hit_joy)) begin
        data_buf_en_n <= 1'b0;
        data_dir_out  <= 1'b1;
        data_dir_oe_n <= 1'b0;
      end
      // joystick write falls through: enable high, float
      if (!ext_buf_en_n) begin
        data_buf_en_n <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read back

  // stands until the next read; unused offsets read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_pulse && cfg_sel) begin
      unique case (cfg_index_r)
        `OFS_FUNC_EN:   rd_data <= {power_ok_r, func_en_r[6:0]};
        `OFS_RST_OPT:   rd_data <= rst_opt_r;
        `OFS_BAUD_SEL:  rd_data <= baud_r;
        `OFS_CLK_BASE:  rd_data <= clk_base_r;
        `OFS_SER1_BASE: rd_data <= ser1_base_r;
        `OFS_SER2_BASE: rd_data <= ser2_base_r;
        `OFS_PRN_BASE:  rd_data <= prn_base_r;
        `OFS_JOY_BASE:  rd_data <= joy_base_r;
        `OFS_IRQ_ROUTE: rd_data <= route_r;
        `OFS_VERIFY:    rd_data <= {4'h0, cfg_index_r};
        default:        rd_data <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // irq routing

  logic [3:0] irq_hit;
  irq_src_t   sel [4];
  logic [3:0] src_b_v;
  logic [3:0] src_a_v;

  // one field per pin; irq3/4 use uart1,uart2, irq5 uart1,printer,
  // irq7 uart2,printer
  assign sel[0] = irq_src_t'(route_r[`LSB_IRQ3 +: 2]);
  assign sel[1] = irq_src_t'(route_r[`LSB_IRQ4 +: 2]);
  assign sel[2] = irq_src_t'(route_r[`LSB_IRQ5 +: 2]);
  assign sel[3] = irq_src_t'(route_r[`LSB_IRQ7 +: 2]);
  assign src_a_v = {irq_ser2_src, irq_ser1_src, irq_ser1_src,
                    irq_ser1_src};
  assign src_b_v = {irq_prn_src, irq_prn_src, irq_ser2_src,
                    irq_ser2_src};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_irq
      // each pin decodes on its own, so sources may fan out
      always_comb begin
        unique case (sel[g])
          src_none: irq_hit[g] = 1'b0;
          src_clk:  irq_hit[g] = irq_clk_src;
          src_a:    irq_hit[g] = src_a_v[g];
          src_b:    irq_hit[g] = src_b_v[g];
        endcase
      end
      // registered pins cost a clock but cannot glitch
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          irq_out[g]  <= 1'b0;
          irq_oe_n[g] <= 1'b1;
        end else begin
          irq_out[g]  <= irq_hit[g];
          irq_oe_n[g] <= !irq_hit[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // reset fan-out and core state

  // bus_reset is a level; cores see it one clock late
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ser_ctrl_reset <= 1'b1;
      clk_irq_reset  <= 1'b1;
      normal_op      <= 1'b0;
      func_enable    <= 5'h00;
      reset_options  <= `RST_RST_OPT;
      baud_select    <= `RST_BAUD_SEL;
    end else begin
      // restricted option shields uarts from bus reset
      ser_ctrl_reset <= bus_reset && !rst_opt_r[`BIT_RST_OPT];
      clk_irq_reset  <= bus_reset;
      normal_op      <= run;
      func_enable    <= run ? func_en_r[4:0] : 5'h00;
      reset_options  <= rst_opt_r;
      baud_select    <= baud_r;
    end
  end

endmodule : multifunction_config_bus_glue

// >>> sim/multifunction_config_bus_glue_monitor.sv
/* assertions on the glue block's ports.
   assumes one core_clk domain and async active high rst. */
`timescale 1ns/10ps
module mfc_glue_monitor (
  // clock and resets
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       bus_reset,
  // host side
  input wire logic       ior_n,
  input wire logic       iow_n,
  input wire logic       ext_buf_en_n,
  input wire logic       irq_clk_src,
  input wire logic       irq_ser1_src,
  input wire logic       irq_ser2_src,
  input wire logic       irq_prn_src,
  // outputs watched
  input wire logic       data_buf_en_n,
  input wire logic       data_dir_out,
  input wire logic       data_dir_oe_n,
  input wire logic [3:0] irq_out,
  input wire logic [3:0] irq_oe_n,
  input wire logic       ser_ctrl_reset,
  input wire logic       clk_irq_reset,
  input wire logic       normal_op,
  input wire logic [7:0] reset_options
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [3:0] src;
  assign src = {irq_prn_src, irq_ser2_src, irq_ser1_src, irq_clk_src};
  //////////////////////////////////////////////////////////////////////
  chk_ext_enable: assert property (
    !ext_buf_en_n |=> !data_buf_en_n) else $error("ext enable lost");
  chk_idle_float: assert property (
    ior_n && iow_n && ext_buf_en_n |=> data_buf_en_n && data_dir_oe_n)
    else $error("buffer active while idle");
  chk_read_dir: assert property (
    !data_dir_oe_n && !$past(ior_n) |-> !data_dir_out)
    else $error("read direction wrong");
  chk_write_dir: assert property (
    !data_dir_oe_n && !$past(iow_n) |-> data_dir_out)
    else $error("write direction wrong");
  chk_irq_level: assert property (
    (~irq_oe_n & ~irq_out) == 4'h0) else $error("irq driven low");
  chk_irq_cause: assert property (
    |(~irq_oe_n) |-> |$past(src)) else $error("irq without source");
  chk_clk_reset: assert property (
    bus_reset |-> ##[0:1] clk_irq_reset) else $error("clock irq not reset");
  chk_serial_keep: assert property (
    reset_options[7] && $past(reset_options[7]) |-> !ser_ctrl_reset)
    else $error("restricted serial reset");
  chk_serial_clear: assert property (
    bus_reset && !reset_options[7] |-> ##[0:1] ser_ctrl_reset)
    else $error("serial control not reset");
  chk_flag_hold: assert property (
    normal_op |=> normal_op) else $error("run flag dropped");
  chk_run_on_write: assert property (
    $rose(normal_op) |-> !$past(iow_n) || !$past(iow_n, 2))
    else $error("run without write");
  cov_read: cover property (!data_dir_oe_n && !data_dir_out);
  cov_write: cover property (!data_dir_oe_n && data_dir_out);
  cov_run: cover property ($rose(normal_op));
endmodule : mfc_glue_monitor

bind multifunction_config_bus_glue mfc_glue_monitor i_mon (
  .core_clk, .rst, .bus_reset, .ior_n, .iow_n, .ext_buf_en_n,
  .irq_clk_src, .irq_ser1_src, .irq_ser2_src, .irq_prn_src,
  .data_buf_en_n, .data_dir_out, .data_dir_oe_n, .irq_out, .irq_oe_n,
  .ser_ctrl_reset, .clk_irq_reset, .normal_op, .reset_options);

// >>> sim/mfc_host_model.sv
/* host i/o bus model with an external address/data mux.
   assumes the bench calls io() from one process at a time. */
`timescale 1ns/10ps
module mfc_host_model (
  // clock
  input  wire logic       core_clk,
  // bus toward the block
  output logic            ale,
  output logic            aen,
  output logic            ior_n,
  output logic            iow_n,
  output logic [9:8]      addr_hi,
  output logic [7:0]      muxed_addr_data,
  // answer from the block
  input  wire logic [7:0] rd_data,
  input  wire logic       data_buf_en_n,
  input  wire logic       data_dir_out,
  input  wire logic       data_dir_oe_n
);
  initial begin
    ale = 1'b0;
    aen = 1'b0;
    ior_n = 1'b1;
    iow_n = 1'b1;
    addr_hi = 2'b00;
    muxed_addr_data = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////
  // strobe held over three edges, wider than the block needs
  task automatic io(input logic wr, input logic dma, input logic [7:0] a,
                    input logic [7:0] d, output logic [7:0] q,
                    output logic [2:0] bufs);
    @(negedge core_clk);
    ale = 1'b1;
    aen = dma;
    muxed_addr_data = a;
    @(negedge core_clk);
    ale = 1'b0;
    muxed_addr_data = wr ? d : ~a;
    if (wr) iow_n = 1'b0;
    else ior_n = 1'b0;
    repeat (3) @(negedge core_clk);
    q = rd_data;
    bufs = {data_buf_en_n, data_dir_out, data_dir_oe_n};
    iow_n = 1'b1;
    ior_n = 1'b1;
    @(negedge core_clk);
    aen = 1'b0;
    // released bus: nothing holds it, so show a moving pattern
    muxed_addr_data = ~muxed_addr_data;
  endtask : io
endmodule : mfc_host_model

// >>> sim/tb_multifunction_config_bus_glue.sv
/* self-checking bench for the config glue block.
   assumes the host model and the bound checker are compiled first. */
`timescale 1ns/10ps
module tb_multifunction_config_bus_glue;
  localparam logic [7:0] DFLT [0:8] = '{8'h00, 8'h00, 8'h00, 8'hb0,
    8'hfe, 8'hbe, 8'h9e, 8'h80, 8'hec};
  logic       core_clk, rst, bus_reset, conn, ext_en_n, cfg_enter;
  logic       ale, aen, ior_n, iow_n, addr_buf_en_n, data_buf_en_n;
  logic       data_dir_out, data_dir_oe_n, ser_ctrl_reset;
  logic       clk_irq_reset, normal_op;
  logic [9:8] addr_hi;
  logic [7:0] mad, rd_data, reset_options, baud_select, q;
  logic [3:0] src, irq_out, irq_oe_n;
  logic [4:0] func_enable;
  logic [2:0] b;
  int         mismatches, n_checks;

  // select pin jumpered to muxed line 4: unit 0
  multifunction_config_bus_glue i_dut (
    .core_clk, .rst, .bus_reset, .ale, .aen, .ior_n, .iow_n, .addr_hi,
    .muxed_addr_data(mad), .unit_select(mad[4]), .unit_select_conn(conn),
    .ext_buf_en_n(ext_en_n), .cfg_enter, .irq_clk_src(src[0]),
    .irq_ser1_src(src[1]), .irq_ser2_src(src[2]), .irq_prn_src(src[3]),
    .addr_buf_en_n, .data_buf_en_n, .data_dir_out, .data_dir_oe_n,
    .rd_data, .irq_out, .irq_oe_n, .ser_ctrl_reset, .clk_irq_reset,
    .normal_op, .func_enable, .reset_options, .baud_select);
  mfc_host_model i_host (
    .core_clk, .ale, .aen, .ior_n, .iow_n, .addr_hi,
    .muxed_addr_data(mad), .rd_data, .data_buf_en_n, .data_dir_out,
    .data_dir_oe_n);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    i_host.io(1'b1, 1'b0, {4'h1, i}, d, q, b);
  endtask : wr
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    i_host.io(1'b0, 1'b0, {4'h1, i}, 8'h00, q, b);
    check(q, e);
    check(b, 3'b000);
  endtask : rd
  task automatic bus_pulse();
    @(negedge core_clk) bus_reset = 1'b1;
    @(negedge core_clk);
  endtask : bus_pulse
  function automatic logic [3:0] exp_oe(logic [1:0] c, logic [3:0] s);
    case (c)
      2'd0: return 4'hf;
      2'd1: return ~{4{s[0]}};
      2'd2: return ~{s[2], s[1], s[1], s[1]};
      default: return ~{s[3], s[3], s[2], s[2]};
    endcase
  endfunction : exp_oe
  //////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    i_host.io(1'b0, 1'b0, 8'h10, 8'h00, q, b);
    check({b[2], b[0]}, 2'b11);
    @(negedge core_clk) cfg_enter = 1'b1;
    @(negedge core_clk) cfg_enter = 1'b0;
    for (int i = 0; i < 9; i++) rd(i[3:0], DFLT[i]);
    check(func_enable, 8'h00);
    check(reset_options, 8'h00);
    check(baud_select, 8'h00);
  endtask : t_defaults
  task automatic t_verify();
    rd(4'hf, 8'h0f);
    wr(4'h8, 8'h5a);
    check(b, 3'b010);
    fork
      i_host.io(1'b1, 1'b1, 8'h18, 8'ha5, q, b);
      repeat (2) @(negedge core_clk) check(addr_buf_en_n, 1'b1);
    join
    check({b[2], b[0]}, 2'b11);
    fork
      rd(4'h8, 8'h5a);
      begin
        repeat (2) @(negedge core_clk);
        check(addr_buf_en_n, 1'b0);
      end
    join
    conn = 1'b0;
    i_host.io(1'b0, 1'b0, 8'h18, 8'h00, q, b);
    check({b[2], b[0]}, 2'b11);
    conn = 1'b1;
    i_host.io(1'b0, 1'b0, 8'h28, 8'h00, q, b);
    check({b[2], b[0]}, 2'b11);
  endtask : t_verify
  task automatic t_irq();
    for (int c = 0; c < 4; c++) begin
      wr(4'h8, {4{c[1:0]}});
      for (int s = 0; s < 4; s++) begin
        @(negedge core_clk) src = 4'h1 << s;
        repeat (2) @(negedge core_clk);
        check(irq_oe_n, exp_oe(c[1:0], src));
        check(irq_out | irq_oe_n, 8'h0f);
      end
    end
    src = 4'h0;
  endtask : t_irq
  task automatic t_bus_reset();
    wr(4'h6, 8'h9c);
    wr(4'h1, 8'h00);
    bus_pulse();
    check({clk_irq_reset, ser_ctrl_reset}, 8'h03);
    bus_reset = 1'b0;
    repeat (2) @(negedge core_clk);
    check({clk_irq_reset, ser_ctrl_reset}, 8'h00);
    rd(4'h6, 8'h9c);
    rd(4'h3, 8'hb0);
    wr(4'h1, 8'h80);
    check(reset_options, 8'h80);
    bus_pulse();
    check({clk_irq_reset, ser_ctrl_reset}, 8'h02);
    bus_reset = 1'b0;
  endtask : t_bus_reset
  task automatic t_finish();
    @(negedge core_clk) ext_en_n = 1'b0;
    @(negedge core_clk) check(data_buf_en_n, 1'b0);
    ext_en_n = 1'b1;
    wr(4'h0, 8'h09);
    wr(4'h6, 8'h01);
    wr(4'h7, 8'h00);
    wr(4'hf, 8'h3c);
    check(normal_op, 1'b1);
    check(func_enable, 8'h09);
    bus_pulse();
    bus_reset = 1'b0;
    check(normal_op, 1'b1);
    i_host.io(1'b1, 1'b0, 8'h18, 8'h00, q, b);
    check({b[2], b[0]}, 2'b11);
    i_host.io(1'b0, 1'b0, 8'h04, 8'h00, q, b);
    check(b, 3'b000);
    i_host.io(1'b1, 1'b0, 8'h04, 8'h77, q, b);
    check(b, 3'b010);
    i_host.io(1'b1, 1'b0, 8'h01, 8'h77, q, b);
    check(b, 3'b101);
  endtask : t_finish
  //////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {bus_reset, cfg_enter, src} = 6'h00;
    {conn, ext_en_n} = 2'b11;
    mismatches = 0;
    n_checks = 0;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_defaults();
    t_verify();
    t_irq();
    t_bus_reset();
    t_finish();
    test_done();
  end
  // full run is under a thousand cycles; allow ample slack
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    test_done();
  end
endmodule : tb_multifunction_config_bus_glue
